/* nvmap_pkg.sv */
// constants and types for the nvm map and protection block
// assumes a 100 MHz system clock and an i2c master on scl/sda
package nvmap_pkg;

  // ==========================================
  // control byte and block address
  localparam logic [3:0] CTRL_CODE = 4'h1;
  localparam logic [2:0] BLK_REG = 3'h0;
  localparam logic [2:0] BLK_NVMC = 3'h2;
  localparam logic [2:0] BLK_EEP = 3'h3;

  // ==========================================
  // register space
  localparam logic [7:0] WPR_ADDR = 8'hE2;
  localparam logic [7:0] LOCK_ADDR = 8'hE4;
  localparam int LOCK_BIT = 0;
  localparam logic [7:0] SOFT_RST_ADDR = 8'hC8;
  localparam int SOFT_RST_BIT = 0;
  localparam int WPR_EN_BIT = 2;
  localparam int WPR_RG_HI = 1;
  localparam int WPR_RG_LO = 0;
  localparam logic [7:0] UNUSED_FILL = 8'hFF;
  localparam logic [7:0] LOAD_LAST = 8'hFF;

  // ==========================================
  // pages
  localparam logic [3:0] PROT_PAGE = 4'hE;
  localparam logic [3:0] SERVICE_PAGE = 4'hF;
  localparam int PAGE_BYTES = 16;
  localparam int NVM_BYTES = 512;
  localparam logic [3:0] BIT_LAST = 4'h8;

  // ==========================================
  // self-timed write cycle
  localparam int CLK_NS = 10;
  localparam int WR_TIME_NS = 20_000_000;
  localparam int WR_CYCLES_DEF = WR_TIME_NS / CLK_NS;
  localparam int BUSY_W = 22;

  typedef enum logic [2:0] {
    ST_LOAD, ST_IDLE, ST_CTRL, ST_WADDR, ST_WDATA, ST_ACK, ST_RDATA, ST_RACK
  } nvmap_st_e;

  typedef struct packed {
    logic [1:0] sclS;
    logic [1:0] sdaS;
    logic sclP;
    logic sdaP;
    nvmap_st_e st;
    nvmap_st_e nxt;
    logic [3:0] bitCnt;
    logic [7:0] sh;
    logic [2:0] blk;
    logic [7:0] addr;
    logic [7:0] rdByte;
    logic sdaOe;
    logic sdaO;
    logic [15:0][7:0] pbuf;
    logic nvmPend;
    logic softPend;
    logic wrStb;
    logic [4:0] wrPage;
    logic busy;
    logic [BUSY_W-1:0] busyCnt;
    logic [7:0] ldCnt;
    logic lock;
    logic [255:0][7:0] regs;
  } nvmap_s;

  typedef struct packed {
    logic [NVM_BYTES-1:0][7:0] mem;
  } nvmap_arr_s;

endpackage

/* nvmap_nvm_if.sv */
// link between the access controller and the nvm array
// assumes both ends run on the same clock
`timescale 1ns/10ps
interface nvmap_nvm_if;
  logic wrStb;
  logic [4:0] wrPage;
  logic [127:0] wrData;
  logic [8:0] rdAddr;
  logic [7:0] rdData;
  modport ctl (output wrStb, output wrPage, output wrData,
               output rdAddr, input rdData);
  modport mem (input wrStb, input wrPage, input wrData,
               input rdAddr, output rdData);
endinterface

/* nvmap_nvm_array.sv */
// 32 pages of 16 bytes, programmed a page at a time
// assumes factory clear only at manufacture, not at device reset
`timescale 1ns/10ps
module nvmap_nvm_array
  import nvmap_pkg::*;
(
  input wire logic clk,
  input wire logic factoryClrN,
  nvmap_nvm_if.mem bus
);

  nvmap_arr_s q;
  nvmap_arr_s d;

  // ==========================================
  // programming
  always_comb begin
    d = q;
    if (bus.wrStb) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        // programming only sets bits; only the factory clear clears them
        d.mem[{bus.wrPage, i[3:0]}] = q.mem[{bus.wrPage, i[3:0]}] |
                                      bus.wrData[i*8 +: 8];
      end
    end
  end

  // content survives device reset; only the factory clear wipes it
  always_ff @(posedge clk or negedge factoryClrN) begin
    if (!factoryClrN) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign bus.rdData = q.mem[bus.rdAddr];

endmodule

/* nvmap_ctrl.sv */
// i2c-facing access controller: address map, page writes, protection
// assumes scl/sda are asynchronous pins and clk is 100 MHz
`timescale 1ns/10ps
module nvmap_ctrl
  import nvmap_pkg::*;
#(
  parameter int WR_CYCLES = WR_CYCLES_DEF
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic factoryClrN,
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  output logic nvmBusy,
  output logic protLocked,
  output logic [7:0] wprState
);

  nvmap_s q;
  nvmap_s d;
  nvmap_nvm_if nvm ();

  logic sclRise;
  logic sclFall;
  logic startC;
  logic stopC;
  logic [7:0] curByte;

  // ==========================================
  // helpers

  // page write allowed for this block and page
  function automatic logic page_ok(input logic [2:0] blk,
                                   input logic [3:0] page,
                                   input logic [7:0] eeprom_write_protect,
                                   input logic lock);
    logic [3:0] thr;
    logic ok;
    thr = {~eeprom_write_protect[WPR_RG_HI], ~eeprom_write_protect[WPR_RG_LO], 2'b00};
    ok = 1'b0;
    if (blk == BLK_NVMC) begin
      ok = (page != SERVICE_PAGE) &&
           !(lock && page == PROT_PAGE);
    end else if (blk == BLK_EEP) begin
      // enable gates the region field completely
      ok = !(eeprom_write_protect[WPR_EN_BIT] && page >= thr);
    end
    return ok; // other blocks never write
  endfunction

  // register byte write allowed
  function automatic logic reg_ok(input logic [7:0] a,
                                  input logic lock);
    // lock freezes the whole protection window
    return !(lock && a[7:4] == PROT_PAGE);
  endfunction

  // block address is a nvm space
  function automatic logic is_nvm(input logic [2:0] blk);
    return blk == BLK_NVMC || blk == BLK_EEP;
  endfunction

  // ==========================================
  // array and read path
  nvmap_nvm_array u_arr (
    .clk(clk),
    .factoryClrN(factoryClrN),
    .bus(nvm.mem)
  );

  // config space sits in the low half of the array
  assign nvm.rdAddr = (q.st == ST_LOAD) ? {1'b0, q.ldCnt} :
                      {q.blk[0], q.addr};
  assign nvm.wrStb = q.wrStb;
  assign nvm.wrPage = q.wrPage;
  assign nvm.wrData = q.pbuf;

  // ==========================================
  // next state
  always_comb begin
    sclRise = q.sclS[1] & ~q.sclP;
    sclFall = ~q.sclS[1] & q.sclP;
    startC = q.sclS[1] & q.sclP & q.sdaP & ~q.sdaS[1];
    stopC = q.sclS[1] & q.sclP & ~q.sdaP & q.sdaS[1];
    // read source by block
    if (q.blk == BLK_REG) begin
      curByte = q.regs[q.addr];
    end else if (is_nvm(q.blk)) begin
      curByte = nvm.rdData; // page 15 stays readable
    end else begin
      curByte = UNUSED_FILL;
    end

    d = q;
    d.wrStb = 1'b0;
    d.sclS = {q.sclS[0], scl};
    d.sdaS = {q.sdaS[0], sdaIn};
    d.sclP = q.sclS[1];
    d.sdaP = q.sdaS[1];

    // self-timed write cycle
    if (q.busy) begin
      if (q.busyCnt == BUSY_W'(WR_CYCLES - 1)) begin
        d.busy = 1'b0;
      end else begin
        d.busyCnt = q.busyCnt + 1'b1;
      end
    end

    case (q.st)
      ST_LOAD: begin
        // registers refresh from the config pages
        d.regs[q.ldCnt] = nvm.rdData;
        if (q.ldCnt == LOCK_ADDR) begin
          d.lock = nvm.rdData[LOCK_BIT];
        end
        if (q.ldCnt == LOAD_LAST) begin
          d.st = ST_IDLE;
        end else begin
          d.ldCnt = q.ldCnt + 1'b1;
        end
      end
      ST_IDLE: begin
        d.sdaOe = 1'b0;
      end
      ST_CTRL, ST_WADDR, ST_WDATA: begin
        if (sclRise) begin
          d.sh = {q.sh[6:0], q.sdaS[1]};
          d.bitCnt = q.bitCnt + 1'b1;
        end else if (sclFall && q.bitCnt == BIT_LAST) begin
          d.st = ST_ACK;
          d.sdaOe = 1'b1;
          d.nxt = ST_WDATA;
          if (q.st == ST_CTRL) begin
            // code, block bits, read/write bit
            if (q.sh[7:4] != CTRL_CODE ||
                (q.busy && is_nvm(q.sh[3:1]))) begin
              // wrong code, or polling while busy: no ack
              d.st = ST_IDLE;
              d.sdaOe = 1'b0;
            end else begin
              d.blk = q.sh[3:1];
              d.nxt = q.sh[0] ? ST_RDATA : ST_WADDR;
            end
          end else if (q.st == ST_WADDR) begin
            d.addr = q.sh;
            d.pbuf = '0;
            d.nvmPend = 1'b0;
            d.softPend = 1'b0;
          end else if (q.blk == BLK_REG) begin
            // byte write to the register space
            if (q.addr == SOFT_RST_ADDR) begin
              d.softPend = q.sh[SOFT_RST_BIT];
            end else if (reg_ok(q.addr, q.lock)) begin
              d.regs[q.addr] = q.sh;
            end
            d.addr = q.addr + 1'b1;
          end else begin
            // bytes wrap within the page
            d.pbuf[q.addr[3:0]] = q.sh;
            d.nvmPend = is_nvm(q.blk);
            d.addr = {q.addr[7:4], q.addr[3:0] + 4'h1};
          end
        end
      end
      ST_ACK: begin
        if (sclFall) begin
          d.sdaOe = 1'b0;
          d.bitCnt = '0;
          d.st = q.nxt;
          if (q.nxt == ST_RDATA) begin
            d.rdByte = curByte;
            d.sdaOe = ~curByte[7];
          end
        end
      end
      ST_RDATA: begin
        if (sclRise) begin
          d.bitCnt = q.bitCnt + 1'b1;
        end else if (sclFall) begin
          if (q.bitCnt == BIT_LAST) begin
            d.sdaOe = 1'b0;
            d.addr = q.addr + 1'b1;
            d.st = ST_RACK;
          end else begin
            d.sdaOe = ~q.rdByte[3'd7 - q.bitCnt[2:0]];
          end
        end
      end
      ST_RACK: begin
        if (sclRise && q.sdaS[1]) begin
          // master nack ends the sequential read
          d.st = ST_IDLE;
        end else if (sclFall) begin
          d.rdByte = curByte;
          d.sdaOe = ~curByte[7];
          d.bitCnt = '0;
          d.st = ST_RDATA;
        end
      end
      default: begin
        d.st = ST_IDLE;
        d.sdaOe = 1'b0;
      end
    endcase

    // bus conditions; ignored while registers reload
    if (q.st != ST_LOAD && startC) begin
      // repeated start keeps the address for random reads
      d.st = ST_CTRL;
      d.bitCnt = '0;
      d.sdaOe = 1'b0;
    end else if (q.st != ST_LOAD && stopC) begin
      d.st = ST_IDLE;
      d.sdaOe = 1'b0;
      d.nvmPend = 1'b0;
      d.softPend = 1'b0;
      // stop launches the page program
      if (q.nvmPend &&
          page_ok(q.blk, q.addr[7:4], q.regs[WPR_ADDR], q.lock)) begin
        d.wrStb = 1'b1;
        d.wrPage = {q.blk[0], q.addr[7:4]};
        d.busy = 1'b1;
        d.busyCnt = '0;
      end
      // soft reset: reload registers and protection
      if (q.softPend) begin
        d.st = ST_LOAD;
        d.ldCnt = '0;
      end
    end
  end

  // ==========================================
  // state register
  // reset lands in ST_LOAD so protection is always read back from nvm
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ==========================================
  // outputs, all straight from flops
  assign sdaOut = q.sdaO;
  assign sdaOe = q.sdaOe;
  assign nvmBusy = q.busy;
  assign protLocked = q.lock;
  assign wprState = q.regs[WPR_ADDR];

endmodule

/* nvmap_ctrl_monitor.sv */
// port checker for the nvm map and protection block
// assumes it is bound onto nvmap_ctrl; one clock domain
`timescale 1ns/10ps
module nvmap_ctrl_monitor #(
  parameter int WR_CYCLES = 2_000_000
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic scl,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic nvmBusy,
  input wire logic protLocked,
  input wire logic [7:0] wprState
);
  // ========
  // helper counters
  logic [8:0] upCnt_q;
  logic [21:0] busyCnt_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      upCnt_q <= '0;
      busyCnt_q <= '0;
    end else begin
      if (upCnt_q != 9'h1ff) upCnt_q <= upCnt_q + 9'h001;
      busyCnt_q <= nvmBusy ? busyCnt_q + 22'h00_0001 : 22'h00_0000;
    end
  end
  // ========
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_busyUp;
    $rose(nvmBusy);
  endsequence
  property p_drainOnly; sdaOut == 1'b0; endproperty
  a_drainOnly: assert property (p_drainOnly)
    else $error("sda driven high");
  property p_oeSclLow; $changed(sdaOe) |-> !scl; endproperty
  a_oeSclLow: assert property (p_oeSclLow)
    else $error("sda moved while scl high");
  property p_busyStop; s_busyUp |-> scl && !sdaOe; endproperty
  a_busyStop: assert property (p_busyStop)
    else $error("write started outside a stop");
  property p_busyLen;
    $fell(nvmBusy) |-> busyCnt_q inside {[WR_CYCLES-1:WR_CYCLES+1]};
  endproperty
  a_busyLen: assert property (p_busyLen)
    else $error("write cycle length wrong");
  property p_busyMax; busyCnt_q <= WR_CYCLES + 1; endproperty
  a_busyMax: assert property (p_busyMax)
    else $error("write cycle overran");
  property p_reloadQuiet; upCnt_q < 9'h100 |-> !sdaOe; endproperty
  a_reloadQuiet: assert property (p_reloadQuiet)
    else $error("bus answered during reload");
  property p_lockFreeze;
    protLocked && $past(protLocked) |-> $stable(wprState);
  endproperty
  a_lockFreeze: assert property (p_lockFreeze)
    else $error("locked protection changed");
  property p_lockScl; $changed(protLocked) |-> scl; endproperty
  a_lockScl: assert property (p_lockScl)
    else $error("lock changed outside reload");
endmodule

bind nvmap_ctrl nvmap_ctrl_monitor #(.WR_CYCLES(WR_CYCLES)) mon (
  .clk(clk), .nrst(nrst), .scl(scl), .sdaOut(sdaOut), .sdaOe(sdaOe),
  .nvmBusy(nvmBusy), .protLocked(protLocked), .wprState(wprState));

/* nvmap_i2c_master.sv */
// i2c bus master model: drives scl, pulls sda low
// assumes a pull-up resolves the sda wire outside
`timescale 1ns/10ps
module nvmap_i2c_master
  import nvmap_pkg::*;
(
  input wire logic sdaLine,
  output logic scl,
  output logic sdaLow
);
  // ========
  // bit level, 125 ns period, free phase
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  task automatic bitIo(input logic b, output logic r);
    #16 sdaLow = !b;
    #46.5 scl = 1'b1;
    #62.5 r = sdaLine;
    scl = 1'b0;
  endtask
  task automatic start();
    #16 sdaLow = 1'b0;
    #46.5 scl = 1'b1;
    #31 sdaLow = 1'b1;
    #31.5 scl = 1'b0;
  endtask
  task automatic stop();
    #16 sdaLow = 1'b1;
    #46.5 scl = 1'b1;
    #31 sdaLow = 1'b0; // scl then stands high
  endtask
  task automatic sendByte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitIo(d[i], r);
    bitIo(1'b1, r);
    ack = !r;
  endtask
  // ========
  // commands
  task automatic wr(input logic [2:0] blk, input logic [7:0] a,
      input logic [15:0][7:0] d, input int n, output logic ok);
    logic k;
    start();
    sendByte({CTRL_CODE, blk, 1'b0}, ok);
    sendByte(a, k);
    ok &= k;
    for (int i = 0; i < n; i++) begin
      sendByte(d[i], k); // each byte once
      ok &= k;
    end
    stop();
  endtask
  task automatic rd(input logic [2:0] blk, input logic [7:0] a,
      output logic [7:0] q);
    logic k;
    start();
    sendByte({CTRL_CODE, blk, 1'b0}, k);
    sendByte(a, k);
    start(); // random read
    sendByte({CTRL_CODE, blk, 1'b1}, k);
    for (int i = 7; i >= 0; i--) bitIo(1'b1, q[i]);
    bitIo(1'b1, k);
    stop();
  endtask
endmodule

/* test_nvm_map_and_eeprom_protect.sv */
// self-checking bench for the nvm map and protection block
// assumes the i2c master model and the bound port checker
`timescale 1ns/10ps
module test_nvm_map_and_eeprom_protect;
  import nvmap_pkg::*;
  localparam int WR = 200;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic factoryClrN = 1'b0;
  logic scl, sdaLow, sdaOut, sdaOe, nvmBusy, protLocked, ok;
  logic [7:0] wprState, q, e0, w;
  logic [15:0][7:0] d;
  logic [3:0] p;
  logic [3:0] perm [16];
  wire logic sdaIn = !(sdaLow | sdaOe);
  int n_mismatch = 0;
  int n_compared = 0;
  always #5 clk = !clk;
  nvmap_ctrl #(.WR_CYCLES(WR)) dut (.clk(clk), .nrst(nrst),
    .factoryClrN(factoryClrN), .scl(scl), .sdaIn(sdaIn), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .nvmBusy(nvmBusy), .protLocked(protLocked),
    .wprState(wprState));
  nvmap_i2c_master m (.sdaLine(sdaIn), .scl(scl), .sdaLow(sdaLow));
  // ========
  // helpers
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  function automatic logic prot(input logic [3:0] pg, input logic [7:0] v);
    return v[WPR_EN_BIT] && pg >= 4'hC - {v[1:0], 2'b00};
  endfunction
  task automatic waitIdle();
    // busy rises a few clocks after the stop; wait for it to show first
    repeat (8) @(posedge clk);
    for (int c = 0; c < 400 && nvmBusy !== 1'b0; c++) @(posedge clk);
  endtask
  task automatic final_report();
    if (n_mismatch == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #950_000;
    n_mismatch++;
    final_report();
  end
  // ========
  // tests
  initial begin
    void'($urandom(32'hfaf9_afeb));
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    factoryClrN <= 1'b1;
    repeat (300) @(posedge clk);
    chk("wprState", 8'h00, wprState);
    for (int i = 0; i < 16; i++) perm[i] = i[3:0];
    for (int i = 15; i > 0; i--) begin
      int j;
      j = $urandom_range(i);
      {perm[i], perm[j]} = {perm[j], perm[i]};
    end
    for (int k = 0; k < 8; k++) begin
      w = {5'h00, k[2:0]};
      d[0] = w;
      m.wr(BLK_REG, WPR_ADDR, d, 1, ok);
      chk("wprState", w, wprState);
      m.rd(BLK_REG, WPR_ADDR, q);
      chk("wprRead", w, q);
      for (int h = 0; h < 2; h++) begin
        p = perm[2*k+h];
        for (int b = 0; b < 16; b++) d[b] = 8'($urandom);
        m.wr(BLK_EEP, {p, 4'h0}, d, 16, ok);
        chk("pageAck", 8'h01, {7'h00, ok});
        if (!prot(p, w)) begin
          m.start();
          m.sendByte({CTRL_CODE, BLK_EEP, 1'b0}, ok);
          m.stop();
          chk("pollAck", 8'h00, {7'h00, ok});
        end
        waitIdle();
        e0 = prot(p, w) ? 8'h00 : d[0];
        m.rd(BLK_EEP, {p, 4'h0}, q);
        chk("eepByte", e0, q);
      end
    end
    p = 4'($urandom_range(13));
    m.wr(BLK_NVMC, {p, 4'h0}, d, 16, ok);
    e0 = d[0];
    waitIdle();
    m.wr(BLK_NVMC, {SERVICE_PAGE, 4'h0}, d, 16, ok);
    waitIdle();
    m.rd(BLK_NVMC, {SERVICE_PAGE, 4'h0}, q);
    chk("service", 8'h00, q);
    for (int b = 1; b < 8; b++) begin
      if (b != 2 && b != 3) begin
        m.rd(b[2:0], 8'($urandom), q);
        chk("unused", UNUSED_FILL, q);
      end
    end
    w = {5'h00, 3'($urandom)};
    d = '0;
    d[2] = w;
    d[4] = 8'h01;
    m.wr(BLK_NVMC, {PROT_PAGE, 4'h0}, d, 16, ok);
    waitIdle();
    chk("lockEarly", 8'h00, {7'h00, protLocked});
    d[0] = 8'h01;
    m.wr(BLK_REG, SOFT_RST_ADDR, d, 1, ok);
    repeat (300) @(posedge clk);
    chk("lock", 8'h01, {7'h00, protLocked});
    chk("wprLoad", w, wprState);
    m.rd(BLK_REG, LOCK_ADDR, q);
    chk("lockReg", 8'h01, q);
    m.rd(BLK_REG, {p, 4'h0}, q);
    chk("regLoad", e0, q);
    d[0] = ~w;
    m.wr(BLK_REG, WPR_ADDR, d, 1, ok);
    chk("wprFrozen", w, wprState);
    d = '0;
    d[2] = 8'h07;
    m.wr(BLK_NVMC, {PROT_PAGE, 4'h0}, d, 16, ok);
    waitIdle();
    d[0] = 8'h01;
    m.wr(BLK_REG, SOFT_RST_ADDR, d, 1, ok);
    repeat (300) @(posedge clk);
    chk("protPage", w, wprState);
    final_report();
  end
endmodule
